// ### hw/mss_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "mss_cfg.svh"

module mss_serial_port #(
	parameter int TIMEOUT_CYC = `MSS_TIMEOUT_CYC
) (
	// System
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// Link pins
	input  wire logic              sclk,
	input  wire logic              sdio_in,
	output logic                   sdio_out,
	output logic                   sdio_oe,
	// Register core side
	output mss_pkg::mss_addr_t     reg_addr,
	output logic                   reg_wr_en,
	output logic [7:0]             reg_wr_data,
	output logic                   reg_rd_req,
	input  wire logic [7:0]        reg_rd_data,
	// Configuration
	output logic [7:0]             config_reg,
	output logic                   soft_rst
);
	import mss_pkg::*;

	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	logic       sclk_s1;
	logic       sclk_s2;
	logic       sclk_s3;
	logic       sdio_s1;
	logic       sdio_s2;
	logic       rise;
	logic       fall;
	mss_state_t state;
	logic [2:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] next_byte;
	logic [7:0] tx;
	logic       byte_done;
	logic       xfer_done;
	logic       active;
	logic [TW-1:0] timer;
	logic       timeout;
	logic       cfg_hit;
	logic       cfg_wr;

	////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			sdio_s1 <= 1'b0;
			sdio_s2 <= 1'b0;
		end else begin
			sclk_s1 <= sclk;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			sdio_s1 <= sdio_in;
			sdio_s2 <= sdio_s1;
		end
	end

	// Data and clock see equal delay, so the sample matches the pin
	assign rise      = sclk_s2 & ~sclk_s3;
	assign fall      = ~sclk_s2 & sclk_s3;
	assign next_byte = {shift[6:0], sdio_s2}; // [R26]
	assign byte_done = rise && (bit_cnt == 3'd7);
	assign cfg_hit   = (reg_addr == `MSS_CFG_ADDR_LO) ||
		(reg_addr == `MSS_CFG_ADDR_HI);
	assign cfg_wr    = (state == MSS_ST_WDATA) && byte_done && cfg_hit;
	assign xfer_done = ((state == MSS_ST_WDATA) ||
		(state == MSS_ST_RDATA)) && byte_done;

	////////////////////////////////////////////////////////////////////
	// Transaction timer

	// Started by the first edge of a command, stopped at its 16th rise.
	// Frozen in power-down, so a partial command there hangs the port.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			active  <= 1'b0;
			timer   <= '0;
			timeout <= 1'b0;
		end else begin
			timeout <= 1'b0;
			if (xfer_done || timeout) begin
				active <= 1'b0;
				timer  <= '0;
			end else if (!active) begin
				if ((rise || fall) && state != MSS_ST_WDATA &&
					state != MSS_ST_RDATA) begin
					active <= 1'b1;
					timer  <= '0;
				end
			end else if (!config_reg[`MSS_PD_BIT]) begin // [R25]
				if (timer == TW'(TIMEOUT_CYC - 1))
					timeout <= 1'b1; // [R13]
				else
					timer <= timer + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Port sequencer

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state       <= MSS_ST_ADDR;
			bit_cnt     <= 3'd0;
			shift       <= 8'h00;
			tx          <= 8'h00;
			reg_addr    <= 7'h00;
			reg_wr_en   <= 1'b0;
			reg_wr_data <= 8'h00;
			reg_rd_req  <= 1'b0;
			sdio_out    <= 1'b0;
			sdio_oe     <= 1'b0;
		end else begin
			reg_wr_en  <= 1'b0;
			reg_rd_req <= 1'b0;
			if (timeout) begin
				state   <= MSS_ST_ADDR; // [R13]
				bit_cnt <= 3'd0;
				sdio_oe <= 1'b0;
			end else begin
				case (state)
				MSS_ST_ADDR: begin
					// Any rise counts, even the first after power-up
					if (rise) begin // [R1] [R3] [R19]
						shift   <= next_byte;
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == 3'd7) begin
							reg_addr <= next_byte[6:0];
							if (next_byte[`MSS_DIR_BIT]) begin
								state <= MSS_ST_WDATA; // [R2]
							end else begin
								state      <= MSS_ST_FETCH; // [R4]
								reg_rd_req <= 1'b1;
							end
						end
					end
				end
				MSS_ST_WDATA: begin
					if (rise) begin // [R3]
						shift   <= next_byte;
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == 3'd7) begin
							state       <= MSS_ST_ADDR;
							reg_wr_data <= next_byte;
							// Unmapped or internal targets stay local
							reg_wr_en <= mss_addr_valid(reg_addr) &&
								!cfg_hit; // [R14]
						end
					end
				end
				MSS_ST_FETCH: begin
					// Core answers in the cycle of the request
					state   <= MSS_ST_RDATA;
					bit_cnt <= 3'd0;
					if (cfg_hit)
						tx <= config_reg;
					else if (mss_addr_valid(reg_addr))
						tx <= reg_rd_data;
					else
						tx <= 8'h00; // [R14]
					// Early look at the top bit; first fall repeats it
					sdio_out <= cfg_hit ? config_reg[7] :
						(mss_addr_valid(reg_addr) & reg_rd_data[7]);
					sdio_oe  <= 1'b1; // [R15] [R16]
				end
				MSS_ST_RDATA: begin
					// Eight falls put out bits 7 down to 0, one per fall
					if (fall) begin // [R3] [R26]
						tx       <= {tx[6:0], 1'b0};
						sdio_out <= tx[7];
					end
					if (rise) begin
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == 3'd7)
							state <= MSS_ST_HOLD;
					end
				end
				MSS_ST_HOLD: begin
					// Last bit stays until the next fall on the clock pin
					if (fall) begin // [R7]
						sdio_oe <= 1'b0; // [R15] [R16]
						state   <= MSS_ST_ADDR;
						bit_cnt <= 3'd0;
					end
				end
				default: begin
					state   <= MSS_ST_ADDR;
					bit_cnt <= 3'd0;
					sdio_oe <= 1'b0;
				end
				endcase
			end
		end
	end
	// Writes never enable the driver, so the pin stays released until the next read [R8] [R9]

	////////////////////////////////////////////////////////////////////
	// Configuration register

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			config_reg <= `MSS_CFG_RESET;
			soft_rst   <= 1'b0;
		end else begin
			soft_rst <= 1'b0;
			if (cfg_wr) begin
				if (config_reg[`MSS_PD_BIT]) begin
					config_reg[`MSS_PD_BIT] <= next_byte[`MSS_PD_BIT]; // [R24]
				end else begin
					config_reg <= next_byte; // [R21] [R23]
					soft_rst   <= next_byte[`MSS_RST_BIT]; // [R21] [R22]
				end
			end else if (config_reg[`MSS_RST_BIT]) begin
				config_reg[`MSS_RST_BIT] <= 1'b0; // [R21]
			end
		end
	end
endmodule
`default_nettype wire

// ### hw/mss_cfg.svh
`ifndef MSS_CFG_SVH
`define MSS_CFG_SVH
// What the document requires of host and sensor
// [R1] Host starts every transfer; sensor only follows clock
// [R2] Write: dir 1, seven-bit address, data byte
// [R3] Drive on falling edge, sample on rising
// [R4] Read: dir 0 address byte, sensor data byte
// [R5] Host releases data before following falling edge
// [R6] Host waits 100 us before data clocks
// [R7] Sensor holds last data bit until falling edge
// [R8] Completed write leaves data pin released
// [R9] Power-down write releases data pin permanently; code still drives it on reads in power-down
// [R10] Back-to-back writes spaced at least 100 us
// [R11] Read after write spaced at least 100 us
// [R12] After read wait 250 ns before next
// [R13] Transaction timer resets port after about 90 ms
// [R14] Bad address write ignored, read returns zero
// [R15] Drive after eighth rise, release within 160 ns
// [R16] Sensor drives only in read data phase
// [R17] Host should drive idle line, not float
// [R18] Host may check sync by reading ID
// [R19] Any rise after power-up is first bit
// [R20] Host idles past timeout to resynchronise
// [R21] Reset bit soft-resets, stores rest, self-clears
// [R22] Analog section needs three frames after reset
// [R23] Power-down is configuration bit six
// [R24] While powered down only bit six written
// [R25] No timeout in power-down; no partial commands
// [R26] Bytes travel most significant bit first

// Configuration register, reachable at either address
`define MSS_CFG_ADDR_LO  7'h00
`define MSS_CFG_ADDR_HI  7'h40
`define MSS_CFG_RESET    8'h00
`define MSS_RST_BIT      7
`define MSS_PD_BIT       6
`define MSS_DIR_BIT      7

// Timing
`define MSS_CLK_HZ       50000000
`define MSS_TIMEOUT_MS   90
`define MSS_TIMEOUT_CYC  (`MSS_TIMEOUT_MS * (`MSS_CLK_HZ / 1000))
`define MSS_RELEASE_NS   160
`define MSS_RELEASE_CYC  ((`MSS_RELEASE_NS * (`MSS_CLK_HZ / 1000000)) / 1000)
`endif

// ### hw/mss_pkg.sv
package mss_pkg;
	typedef enum logic [2:0] {
		MSS_ST_ADDR  = 3'b000,
		MSS_ST_WDATA = 3'b001,
		MSS_ST_FETCH = 3'b010,
		MSS_ST_RDATA = 3'b011,
		MSS_ST_HOLD  = 3'b100
	} mss_state_t;

	typedef logic [6:0] mss_addr_t;

	function automatic logic mss_addr_valid(input mss_addr_t a);
		mss_addr_valid = (a <= 7'h0B) ||
			(a >= 7'h14 && a <= 7'h1B) ||
			(a == 7'h33) ||
			(a >= 7'h40 && a <= 7'h4A);
	endfunction
endpackage

// ### dv/mss_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module mss_monitor #(
	parameter int TIMEOUT_CYC = 200
) (
	// System
	input wire logic               sys_clk,
	input wire logic               sys_rst,
	// Link pins
	input wire logic               sclk,
	input wire logic               sdio_in,
	input wire logic               sdio_out,
	input wire logic               sdio_oe,
	// Register core side
	input wire mss_pkg::mss_addr_t reg_addr,
	input wire logic               reg_wr_en,
	input wire logic [7:0]         reg_wr_data,
	input wire logic               reg_rd_req,
	input wire logic [7:0]         reg_rd_data,
	// Configuration
	input wire logic [7:0]         config_reg,
	input wire logic               soft_rst
);
	logic [3:0] lo_cnt;
	// Cycles of low clock pin while still driving; longer means a stuck drive
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst)
			lo_cnt <= 4'h0;
		else
			lo_cnt <= (sdio_oe && !sclk) ? lo_cnt + 4'h1 : 4'h0;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_drive;
		reg_rd_req ##1 sdio_oe;
	endsequence
	sequence s_soft;
		soft_rst ##1 !soft_rst;
	endsequence
	a_rd_then_drive: assert property (reg_rd_req |-> s_drive)
		else $error("no drive after read request");
	a_drive_cause: assert property ($rose(sdio_oe) |-> $past(reg_rd_req))
		else $error("drive without read");
	a_hold_to_fall: assert property ($fell(sdio_oe) |-> !sclk)
		else $error("released before clock fall");
	a_release_bound: assert property (lo_cnt < 4'h8)
		else $error("late release");
	a_wr_no_drive: assert property (reg_wr_en |-> !sdio_oe)
		else $error("driving during write");
	a_wr_pulse_addr: assert property (reg_wr_en |->
		(reg_addr != 7'h00 && reg_addr != 7'h40) ##1 !reg_wr_en)
		else $error("bad write strobe");
	a_rd_pulse: assert property (reg_rd_req |=> !reg_rd_req)
		else $error("read request too long");
	a_rst_self_clear: assert property (config_reg[7] |=> !config_reg[7])
		else $error("reset bit stuck");
	a_soft_pulse: assert property ($rose(config_reg[7]) |-> ##[0:1] s_soft)
		else $error("no soft reset pulse");
	a_pd_keep_bits: assert property ($past(config_reg[6]) |->
		$stable(config_reg[5:0]) && !config_reg[7])
		else $error("config changed in power-down");
endmodule
bind mss_serial_port mss_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) mon_u (
	.sys_clk, .sys_rst, .sclk, .sdio_in, .sdio_out, .sdio_oe, .reg_addr,
	.reg_wr_en, .reg_wr_data, .reg_rd_req, .reg_rd_data, .config_reg,
	.soft_rst);
`default_nettype wire

// ### dv/mss_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module mss_host_model (
	// Sensor side
	input wire logic sdio_out,
	input wire logic sdio_oe,
	// Wire level
	output logic     sclk,
	output logic     sdio_in
);
	logic hd;
	logic hoe;
	// Released line shows the inverse so stale data never passes
	always_comb sdio_in = sdio_oe ? sdio_out : (hoe ? hd : ~hd);
	initial begin
		sclk = 1'b1;
		hd = 1'b1;
		hoe = 1'b1;
	end
	task automatic send(input logic [7:0] v, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			sclk = 1'b0;
			hd = v[i];
			#80 sclk = 1'b1;
			#80;
		end
	endtask
	task automatic xfer(input logic [7:0] a, d, output logic [7:0] q);
		send(a, 8);
		q = 8'h00;
		if (a[7]) begin
			send(d, 8);
			#100us;
		end else begin
			hoe = 1'b0;
			#100us;
			for (int i = 7; i >= 0; i--) begin
				sclk = 1'b0;
				#80 sclk = 1'b1;
				#80 q[i] = sdio_in;
			end
			#180 sclk = 1'b0;
			#200 hoe = 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import mss_pkg::*;
	localparam int TO = 8000;
	logic sys_clk, sys_rst, sclk, sdio_in, sdio_out, sdio_oe;
	logic reg_wr_en, reg_rd_req, soft_rst;
	logic [7:0] reg_wr_data, reg_rd_data, config_reg, q, wd;
	mss_addr_t reg_addr, wa;
	int n_mismatch, n_checks, n_wr, n_soft, cyc, n0, s0;
	mss_serial_port #(.TIMEOUT_CYC(TO)) dut_u (.sys_clk, .sys_rst, .sclk,
		.sdio_in, .sdio_out, .sdio_oe, .reg_addr, .reg_wr_en, .reg_wr_data,
		.reg_rd_req, .reg_rd_data, .config_reg, .soft_rst);
	mss_host_model host_u (.sdio_out, .sdio_oe, .sclk, .sdio_in);
	always #10 sys_clk = ~sys_clk;
	always @(negedge sys_clk) reg_rd_data <= {1'b1, reg_addr} ^ 8'h3C;
	function automatic logic [7:0] f(input mss_addr_t a);
		return {1'b1, a} ^ 8'h3C;
	endfunction
	always @(posedge sys_clk) begin
		cyc++;
		if (soft_rst === 1'b1) n_soft++;
		if (reg_wr_en === 1'b1) begin
			n_wr++;
			wa = reg_addr;
			wd = reg_wr_data;
		end
		if (cyc == 90000) begin
			n_mismatch++;
			results();
		end
	end
	task chk(input string nm, input logic [7:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task results();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task t_writes();
		n0 = n_wr;
		host_u.xfer(8'h9A, 8'hA5, q);
		chk("wr", n_wr - n0, 1);
		chk("wr addr", wa, 8'h1A);
		chk("wr data", wd, 8'hA5);
		host_u.xfer(8'hF7, 8'h00, q);
		chk("bad wr", n_wr - n0, 1);
		chk("oe", sdio_oe, 0);
	endtask
	task t_reads();
		mss_addr_t t[4] = '{7'h41, 7'h33, 7'h77, 7'h0C};
		foreach (t[i]) begin
			host_u.xfer({1'b0, t[i]}, 8'h00, q);
			chk("rd", q, i > 1 ? 8'h00 : f(t[i]));
			chk("oe", sdio_oe, 0);
		end
	endtask
	task t_cfg();
		s0 = n_soft;
		host_u.xfer(8'h80, 8'h81, q);
		chk("cfg", config_reg, 8'h01);
		chk("soft", n_soft - s0, 1);
		host_u.xfer(8'h00, 8'h00, q);
		chk("cfg rd", q, 8'h01);
		host_u.xfer(8'hC0, 8'h41, q);
		chk("pd", config_reg, 8'h41);
		chk("oe", sdio_oe, 0);
		host_u.xfer(8'hC0, 8'hA6, q);
		chk("pd wr", config_reg, 8'h01);
		chk("soft", n_soft - s0, 1);
	endtask
	task t_timeout();
		host_u.send(8'hFF, 5);
		#200us;
		host_u.xfer(8'h41, 8'h00, q);
		chk("resync", q, f(7'h41));
	endtask
	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		reg_rd_data = 8'h00;
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		// Clock pin high at release counts as a bit; let the timer clear it
		#170us;
		t_writes();
		t_reads();
		t_cfg();
		t_timeout();
		results();
	end
endmodule
`default_nettype wire
